// file: hdl/charge_setpoint_map.vh
// Offsets, field positions, reset values and decode constants of the charge setpoint registers
`ifndef CHARGE_SETPOINT_MAP_VH
`define CHARGE_SETPOINT_MAP_VH
`define ADDR_CHARGE_CURRENT_CONTROL  8'h02
`define ADDR_PRECHARGE_TERM_CURRENT  8'h03
`define ADDR_CHARGE_VOLTAGE_CONTROL  8'h04
`define RST_CHARGE_CURRENT_CONTROL   8'hb4
`define RST_PRECHARGE_TERM_CURRENT   8'haa
`define RST_CHARGE_VOLTAGE_CONTROL   8'h58
`define BIT_BOOST_LIMIT              7
`define BIT_INPUT_SWITCH_FULL_ON     6
`define BIT_RECHARGE_OFFSET          0
`define BOOST_LIMIT_LOW_MA           12'h1f4
`define BOOST_LIMIT_HIGH_MA          12'h4b0
`define INPUT_SWITCH_THRESHOLD_MA    12'h2bc
`define VREG_OFFSET_MV               13'h0f10
`define VREG_STEP_MV                 13'h0020
`define VREG_SPECIAL_CODE            5'h0f
`define VREG_SPECIAL_MV              13'h10fe
`define VREG_MAX_CODE                5'h18
`define RECHARGE_LOW_MV              13'h0064
`define RECHARGE_HIGH_MV             13'h00c8
`define ICHG_MAX_MA                  12'hbb8
`define TOPOFF_STEP_MIN              6'h0f
`endif

// file: hdl/charge_setpoint_registers.v
// Charge setpoint register bank with decoders for currents, voltage and recharge
//
// How it works
// - Boost limit bit: 0.5A clear, 1.2A set
// - Full-on clear: high-resistance switch below 700mA
// - Boost mode always drives input switch fully on
// - Fast-charge code resets to 110100 (1980mA)
// - Fast-charge lower half piecewise decode
// - Fast-charge upper half decode, 61-63 give 3000mA
// - Precharge and termination codes reset to 1010
// - Shared four-bit precharge/termination current mapping
// - Charge voltage 3856mV plus 32mV per step, except code 01111 (4350mV)
// - Voltage codes above 24 clamp to 24
// - Voltage code resets to 01011 (4.208V)
// - Top-off field selects 0/15/30/45 minutes
// - Top-off 00 ends charging at termination
// - Recharge offset 100mV clear, 200mV set
// - Recharge starts below setpoint minus offset
// - All registers eight bits, bit 0 LSB
`timescale 1ns/100ps
`default_nettype none
`include "charge_setpoint_map.vh"
module charge_setpoint_registers
(
   input  wire        i_sys_clk,
   input  wire        i_rst,
   input  wire        i_reg_reset,
   input  wire        i_watchdog_expired,
   input  wire        i_wr_en,
   input  wire        i_rd_en,
   input  wire [7:0]  i_addr,
   input  wire [7:0]  i_wr_data,
   output reg  [7:0]  o_rd_data,
   output reg         o_rd_hit,
   input  wire        i_boost_mode,
   input  wire [11:0] i_input_current_limit_setting,
   input  wire        i_charge_done,
   input  wire [12:0] i_battery_mv,
   input  wire        i_termination_met,
   input  wire        i_topoff_expired,
   output reg  [11:0] o_boost_current_limit_ma,
   output reg         o_input_switch_full_on,
   output reg  [11:0] o_fast_charge_ma,
   output reg  [7:0]  o_precharge_ma,
   output reg  [7:0]  o_termination_ma,
   output reg  [12:0] o_charge_voltage_mv,
   output reg  [5:0]  o_topoff_minutes,
   output reg         o_charge_end,
   output reg  [12:0] o_recharge_threshold_mv,
   output reg         o_recharge_start
);

   reg  [7:0]  charge_current_control_reg;
   reg  [7:0]  precharge_termination_current_reg;
   reg  [7:0]  charge_voltage_control_reg;
   reg  [7:0]  charge_current_control_next;
   reg  [7:0]  precharge_termination_current_next;
   reg  [7:0]  charge_voltage_control_next;

   wire [5:0]  fast_charge_current_code = charge_current_control_reg[5:0];
   wire [3:0]  precharge_current_code   = precharge_termination_current_reg[7:4];
   wire [3:0]  termination_current_code = precharge_termination_current_reg[3:0];
   wire [4:0]  charge_voltage_code      = charge_voltage_control_reg[7:3];
   wire [1:0]  topoff_extension_sel     = charge_voltage_control_reg[2:1];
   wire        recharge_offset_sel      = charge_voltage_control_reg[`BIT_RECHARGE_OFFSET];
   wire        boost_current_limit_sel  = charge_current_control_reg[`BIT_BOOST_LIMIT];
   wire        input_switch_full_on     = charge_current_control_reg[`BIT_INPUT_SWITCH_FULL_ON];

   // Shared by precharge and termination decode
   function [7:0] small_current_ma;
      input [3:0] code;
      begin
         case (code)
            4'h0: small_current_ma = 8'h05;
            4'h1: small_current_ma = 8'h0a;
            4'h2: small_current_ma = 8'h0f;
            4'h3: small_current_ma = 8'h14;
            4'h4: small_current_ma = 8'h1e;
            4'h5: small_current_ma = 8'h28;
            4'h6: small_current_ma = 8'h32;
            4'h7: small_current_ma = 8'h3c;
            4'h8: small_current_ma = 8'h50;
            4'h9: small_current_ma = 8'h64;
            4'ha: small_current_ma = 8'h78;
            4'hb: small_current_ma = 8'h8c;
            4'hc: small_current_ma = 8'ha0;
            4'hd: small_current_ma = 8'hb4;
            4'he: small_current_ma = 8'hc8;
            default: small_current_ma = 8'hf0;
         endcase
      end
   endfunction

   // Table form: six step sizes make shared arithmetic easy to get wrong
   function [11:0] fast_current_ma;
      input [5:0] code;
      begin
         case (code)
            6'h00: fast_current_ma = 12'h000;
            6'h01: fast_current_ma = 12'h005;
            6'h02: fast_current_ma = 12'h00a;
            6'h03: fast_current_ma = 12'h00f;
            6'h04: fast_current_ma = 12'h014;
            6'h05: fast_current_ma = 12'h019;
            6'h06: fast_current_ma = 12'h01e;
            6'h07: fast_current_ma = 12'h023;
            6'h08: fast_current_ma = 12'h028;
            6'h09: fast_current_ma = 12'h032;
            6'h0a: fast_current_ma = 12'h03c;
            6'h0b: fast_current_ma = 12'h046;
            6'h0c: fast_current_ma = 12'h050;
            6'h0d: fast_current_ma = 12'h05a;
            6'h0e: fast_current_ma = 12'h064;
            6'h0f: fast_current_ma = 12'h06e;
            6'h10: fast_current_ma = 12'h082;
            6'h11: fast_current_ma = 12'h096;
            6'h12: fast_current_ma = 12'h0aa;
            6'h13: fast_current_ma = 12'h0be;
            6'h14: fast_current_ma = 12'h0d2;
            6'h15: fast_current_ma = 12'h0e6;
            6'h16: fast_current_ma = 12'h0fa;
            6'h17: fast_current_ma = 12'h10e;
            6'h18: fast_current_ma = 12'h12c;
            6'h19: fast_current_ma = 12'h14a;
            6'h1a: fast_current_ma = 12'h168;
            6'h1b: fast_current_ma = 12'h186;
            6'h1c: fast_current_ma = 12'h1a4;
            6'h1d: fast_current_ma = 12'h1c2;
            6'h1e: fast_current_ma = 12'h1e0;
            6'h1f: fast_current_ma = 12'h1fe;
            6'h20: fast_current_ma = 12'h21c;
            6'h21: fast_current_ma = 12'h258;
            6'h22: fast_current_ma = 12'h294;
            6'h23: fast_current_ma = 12'h2d0;
            6'h24: fast_current_ma = 12'h30c;
            6'h25: fast_current_ma = 12'h348;
            6'h26: fast_current_ma = 12'h384;
            6'h27: fast_current_ma = 12'h3c0;
            6'h28: fast_current_ma = 12'h3fc;
            6'h29: fast_current_ma = 12'h438;
            6'h2a: fast_current_ma = 12'h474;
            6'h2b: fast_current_ma = 12'h4b0;
            6'h2c: fast_current_ma = 12'h4ec;
            6'h2d: fast_current_ma = 12'h528;
            6'h2e: fast_current_ma = 12'h564;
            6'h2f: fast_current_ma = 12'h5a0;
            6'h30: fast_current_ma = 12'h5dc;
            6'h31: fast_current_ma = 12'h654;
            6'h32: fast_current_ma = 12'h6cc;
            6'h33: fast_current_ma = 12'h744;
            6'h34: fast_current_ma = 12'h7bc;
            6'h35: fast_current_ma = 12'h834;
            6'h36: fast_current_ma = 12'h8ac;
            6'h37: fast_current_ma = 12'h924;
            6'h38: fast_current_ma = 12'h99c;
            6'h39: fast_current_ma = 12'ha14;
            6'h3a: fast_current_ma = 12'ha8c;
            6'h3b: fast_current_ma = 12'hb04;
            6'h3c: fast_current_ma = 12'hb7c;
            default: fast_current_ma = `ICHG_MAX_MA;
         endcase
      end
   endfunction

   // Clamp first so an over-range code never lands on the special value
   function [12:0] charge_voltage_mv;
      input [4:0] code;
      reg   [4:0] eff;
      begin
         eff = (code > `VREG_MAX_CODE) ? `VREG_MAX_CODE : code;
         if (eff == `VREG_SPECIAL_CODE)
            charge_voltage_mv = `VREG_SPECIAL_MV;
         else
            charge_voltage_mv = `VREG_OFFSET_MV + {8'h00, eff} * `VREG_STEP_MV;
      end
   endfunction

   always @*
   begin
      charge_current_control_next        = charge_current_control_reg;
      precharge_termination_current_next = precharge_termination_current_reg;
      charge_voltage_control_next        = charge_voltage_control_reg;
      if (i_reg_reset)
      begin
         charge_current_control_next        = `RST_CHARGE_CURRENT_CONTROL;
         precharge_termination_current_next = `RST_PRECHARGE_TERM_CURRENT;
         charge_voltage_control_next        = `RST_CHARGE_VOLTAGE_CONTROL;
      end
      else if (i_watchdog_expired)
      begin
         // Full-on bit survives watchdog expiry
         charge_current_control_next = {1'b1, input_switch_full_on, 6'h34};
         precharge_termination_current_next = `RST_PRECHARGE_TERM_CURRENT;
         charge_voltage_control_next        = `RST_CHARGE_VOLTAGE_CONTROL;
      end
      else if (i_wr_en)
      begin
         case (i_addr)
            `ADDR_CHARGE_CURRENT_CONTROL:
               charge_current_control_next = i_wr_data;
            `ADDR_PRECHARGE_TERM_CURRENT:
               precharge_termination_current_next = i_wr_data;
            `ADDR_CHARGE_VOLTAGE_CONTROL:
               charge_voltage_control_next = i_wr_data;
            default:
               charge_current_control_next = charge_current_control_reg;
         endcase
      end
   end

   always @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         charge_current_control_reg        <= `RST_CHARGE_CURRENT_CONTROL;
         precharge_termination_current_reg <= `RST_PRECHARGE_TERM_CURRENT;
         charge_voltage_control_reg        <= `RST_CHARGE_VOLTAGE_CONTROL;
      end
      else
      begin
         charge_current_control_reg        <= charge_current_control_next;
         precharge_termination_current_reg <= precharge_termination_current_next;
         charge_voltage_control_reg        <= charge_voltage_control_next;
      end
   end

   // Read data registered; unmapped addresses read zero with no hit
   always @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         o_rd_data <= 8'h00;
         o_rd_hit  <= 1'b0;
      end
      else
      begin
         o_rd_hit  <= 1'b0;
         o_rd_data <= 8'h00;
         if (i_rd_en)
         begin
            case (i_addr)
               `ADDR_CHARGE_CURRENT_CONTROL:
               begin
                  o_rd_data <= charge_current_control_reg;
                  o_rd_hit  <= 1'b1;
               end
               `ADDR_PRECHARGE_TERM_CURRENT:
               begin
                  o_rd_data <= precharge_termination_current_reg;
                  o_rd_hit  <= 1'b1;
               end
               `ADDR_CHARGE_VOLTAGE_CONTROL:
               begin
                  o_rd_data <= charge_voltage_control_reg;
                  o_rd_hit  <= 1'b1;
               end
               default:
                  o_rd_hit  <= 1'b0;
            endcase
         end
      end
   end

   wire [12:0] vreg_mv     = charge_voltage_mv(charge_voltage_code);
   wire [12:0] recharge_mv = vreg_mv - (recharge_offset_sel ? `RECHARGE_HIGH_MV
                                                             : `RECHARGE_LOW_MV);

   // Decoded setpoints are registered so they change one edge after the field
   always @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         o_boost_current_limit_ma <= `BOOST_LIMIT_HIGH_MA;
         o_input_switch_full_on   <= 1'b0;
         o_fast_charge_ma         <= 12'h7bc;
         o_precharge_ma           <= 8'h78;
         o_termination_ma         <= 8'h78;
         o_charge_voltage_mv      <= 13'h1070;
         o_topoff_minutes         <= 6'h00;
         o_charge_end             <= 1'b0;
         o_recharge_threshold_mv  <= 13'h100c;
         o_recharge_start         <= 1'b0;
      end
      else
      begin
         o_boost_current_limit_ma <= boost_current_limit_sel ? `BOOST_LIMIT_HIGH_MA
                                                             : `BOOST_LIMIT_LOW_MA;
         o_input_switch_full_on   <= i_boost_mode | input_switch_full_on |
            (i_input_current_limit_setting >= `INPUT_SWITCH_THRESHOLD_MA);
         o_fast_charge_ma         <= fast_current_ma(fast_charge_current_code);
         o_precharge_ma           <= small_current_ma(precharge_current_code);
         o_termination_ma         <= small_current_ma(termination_current_code);
         o_charge_voltage_mv      <= vreg_mv;
         o_topoff_minutes         <= {4'h0, topoff_extension_sel} * `TOPOFF_STEP_MIN;
         o_charge_end             <= i_termination_met &&
            ((topoff_extension_sel == 2'b00) || i_topoff_expired);
         o_recharge_threshold_mv  <= recharge_mv;
         o_recharge_start         <= i_charge_done && (i_battery_mv < recharge_mv);
      end
   end

endmodule // charge_setpoint_registers
`default_nettype wire

// file: tb/host_model.sv
// Host side register access model
`timescale 1ns/100ps
`default_nettype none
module host_model
(
   input  wire logic       i_sys_clk,
   input  wire logic [7:0] i_rd_data,
   input  wire logic       i_rd_hit,
   output var  logic       o_wr_en = 1'b0,
   output var  logic       o_rd_en = 1'b0,
   output var  logic [7:0] o_addr = 8'h00,
   output var  logic [7:0] o_wr_data = 8'h00
);
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      o_wr_en <= 1'b1;
      o_addr <= a;
      o_wr_data <= d;
      @(posedge i_sys_clk);
      o_wr_en <= 1'b0;
      // Released lines must not keep the old value
      o_addr <= ~a;
      o_wr_data <= ~d;
   endtask
   task automatic read(input logic [7:0] a, output logic [7:0] d, output logic h);
      @(posedge i_sys_clk);
      o_rd_en <= 1'b1;
      o_addr <= a;
      @(posedge i_sys_clk);
      o_rd_en <= 1'b0;
      o_addr <= ~a;
      #1;
      d = i_rd_data;
      h = i_rd_hit;
   endtask
endmodule // host_model
`default_nettype wire

// file: tb/charge_setpoint_properties.sv
// Port checker for the charge setpoint register bank
`timescale 1ns/100ps
`default_nettype none
module charge_setpoint_checker
(
   input wire logic        i_sys_clk, i_rst, i_rd_en, i_boost_mode, i_reg_reset,
   input wire logic        i_charge_done, i_termination_met, o_rd_hit,
   input wire logic        o_input_switch_full_on, o_recharge_start, o_charge_end,
   input wire logic [7:0]  i_addr, o_rd_data,
   input wire logic [5:0]  o_topoff_minutes,
   input wire logic [11:0] o_boost_current_limit_ma, o_fast_charge_ma,
   input wire logic [12:0] i_battery_mv, o_charge_voltage_mv, o_recharge_threshold_mv
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   wire logic mapped = (i_addr >= 8'h02) && (i_addr <= 8'h04);
   a_read_hit_mapped: assert property (i_rd_en && mapped |=> o_rd_hit)
      else $error("mapped read without hit");
   a_read_idle_zero: assert property (!i_rd_en || !mapped |=> !o_rd_hit && o_rd_data == 8'h00)
      else $error("read data not zero");
   a_boost_full_on: assert property (i_boost_mode [*3] |-> o_input_switch_full_on)
      else $error("boost without full switch");
   a_reset_setpoints: assert property (i_reg_reset [*3] |-> o_boost_current_limit_ma == 12'h4b0
      && o_fast_charge_ma == 12'h7bc && o_charge_voltage_mv == 13'h1070) else $error("bad reset setpoints");
   a_voltage_clamp: assert property (o_charge_voltage_mv <= 13'h1210)
      else $error("voltage above clamp");
   a_recharge_gap: assert property ($stable(o_charge_voltage_mv) [*2] |->
      (o_charge_voltage_mv - o_recharge_threshold_mv) inside {13'h0064, 13'h00c8}) else $error("bad gap");
   // Threshold stable next cycle proves the field did not just move
   a_recharge_start: assert property (i_charge_done && i_battery_mv < o_recharge_threshold_mv
      ##1 $stable(o_recharge_threshold_mv) |-> o_recharge_start) else $error("recharge missed");
   a_no_recharge: assert property (!i_charge_done |=> !o_recharge_start)
      else $error("recharge while not done");
   a_end_no_topoff: assert property (i_termination_met && o_topoff_minutes == 6'h00
      ##1 o_topoff_minutes == 6'h00 |-> o_charge_end) else $error("charge end missed");
   c_mapped_read: cover property (i_rd_en && mapped);
   c_recharge: cover property (o_recharge_start);
   c_charge_end: cover property (o_charge_end);
endmodule // charge_setpoint_checker
bind charge_setpoint_registers charge_setpoint_checker u_chk (.*);
`default_nettype wire

// file: tb/charge_setpoint_registers_test.sv
// Self-checking bench for the charge setpoint register bank
`timescale 1ns/100ps
`default_nettype none
module charge_setpoint_registers_test;
   logic i_sys_clk = 0, i_rst = 1, i_reg_reset = 0, i_watchdog_expired = 0, i_boost_mode = 0;
   logic i_charge_done = 0, i_termination_met = 0, i_topoff_expired = 0;
   logic [11:0] i_input_current_limit_setting = 12'h2bc;
   logic [12:0] i_battery_mv = 13'h1fff;
   wire logic i_wr_en, i_rd_en, o_rd_hit, o_input_switch_full_on, o_charge_end, o_recharge_start;
   wire logic [7:0] i_addr, i_wr_data, o_rd_data, o_precharge_ma, o_termination_ma;
   wire logic [11:0] o_boost_current_limit_ma, o_fast_charge_ma;
   wire logic [12:0] o_charge_voltage_mv, o_recharge_threshold_mv;
   wire logic [5:0] o_topoff_minutes;
   int bad_count = 0, total_checks = 0;
   logic [7:0] rv;
   logic rh;
   logic [12:0] v;
   host_model host (.i_sys_clk, .i_rd_data(o_rd_data), .i_rd_hit(o_rd_hit), .o_wr_en(i_wr_en),
      .o_rd_en(i_rd_en), .o_addr(i_addr), .o_wr_data(i_wr_data));
   charge_setpoint_registers DUT (.*);
   initial forever #4 i_sys_clk = ~i_sys_clk;
   task chk(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask
   task set(input logic [7:0] a, input logic [7:0] d);
      host.write(a, d);
      tick(1);
   endtask
   function automatic logic [11:0] fast_ma(input logic [5:0] c);
      if (c <= 8) return 12'(c * 5);
      if (c < 16) return 12'(40 + (c - 8) * 10);
      if (c < 24) return 12'(130 + (c - 16) * 20);
      if (c < 32) return 12'(300 + (c - 24) * 30);
      if (c < 48) return 12'(540 + (c - 32) * 60);
      if (c < 61) return 12'(1500 + (c - 48) * 120);
      return 12'hbb8;
   endfunction
   function automatic logic [7:0] pt_ma(input logic [3:0] c);
      if (c < 4) return 8'(5 + c * 5);
      if (c < 8) return 8'(30 + (c - 4) * 10);
      if (c < 15) return 8'(80 + (c - 8) * 20);
      return 8'hf0;
   endfunction
   task t_codes;
      host.read(8'h03, rv, rh);
      chk({rv, 7'h00, rh}, 16'haa01);
      chk(o_recharge_threshold_mv, 13'h100c);
      for (int c = 0; c < 64; c++)
      begin
         set(8'h02, {2'b01, c[5:0]});
         chk(o_fast_charge_ma, fast_ma(c[5:0]));
         chk(o_boost_current_limit_ma, 12'h1f4);
         set(8'h03, {c[3:0], ~c[3:0]});
         chk({o_precharge_ma, o_termination_ma}, {pt_ma(c[3:0]), pt_ma(~c[3:0])});
         if (c >= 32)
            continue;
         set(8'h04, {c[4:0], c[2:0]});
         v = c == 15 ? 13'h10fe : c > 24 ? 13'h1210 : 13'(3856 + c * 32);
         chk(o_charge_voltage_mv, v);
         chk(o_recharge_threshold_mv, v - (c[0] ? 13'h00c8 : 13'h0064));
         chk(o_topoff_minutes, 6'(c[2:1] * 15));
      end
      $display("code decode test done");
   endtask
   task t_resets;
      set(8'h03, 8'h00);
      @(posedge i_sys_clk);
      i_watchdog_expired <= 1'b1;
      @(posedge i_sys_clk);
      i_watchdog_expired <= 1'b0;
      host.read(8'h02, rv, rh);
      chk(rv, 8'hf4);
      host.read(8'h03, rv, rh);
      chk(rv, 8'haa);
      chk(o_charge_voltage_mv, 13'h1070);
      chk(o_boost_current_limit_ma, 12'h4b0);
      @(posedge i_sys_clk);
      i_reg_reset <= 1'b1;
      i_input_current_limit_setting <= 12'h2bb;
      tick(3);
      @(posedge i_sys_clk);
      i_reg_reset <= 1'b0;
      host.read(8'h02, rv, rh);
      chk(rv, 8'hb4);
      chk(o_input_switch_full_on, 1'b0);
      set(8'h02, 8'h40);
      chk(o_input_switch_full_on, 1'b1);
      set(8'h02, 8'hb4);
      $display("reset test done");
   endtask
   task t_switch_recharge;
      @(posedge i_sys_clk);
      i_input_current_limit_setting <= 12'h2bc;
      i_charge_done <= 1'b1;
      i_battery_mv <= 13'h100b;
      i_termination_met <= 1'b1;
      tick(2);
      chk({o_input_switch_full_on, o_recharge_start, o_charge_end}, 3'b111);
      @(posedge i_sys_clk);
      i_boost_mode <= 1'b1;
      i_input_current_limit_setting <= 12'h064;
      i_battery_mv <= 13'h100c;
      tick(3);
      chk({o_input_switch_full_on, o_recharge_start}, 2'b10);
      set(8'h04, 8'h5a);
      set(8'h05, 8'h00);
      chk(o_charge_end, 1'b0);
      @(posedge i_sys_clk);
      i_topoff_expired <= 1'b1;
      host.read(8'h05, rv, rh);
      chk({rv, 3'h0, rh, 3'h0, o_charge_end}, 16'h0001);
      $display("switch and recharge test done");
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #100000;
      bad_count++;
      end_of_test;
   end
   initial
   begin
      repeat (6) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      t_codes;
      t_resets;
      t_switch_recharge;
      end_of_test;
   end
endmodule // charge_setpoint_registers_test
`default_nettype wire
